// [core/cst_slave_tx.sv]
// Purpose: three-wire serial slave transmit channel with AXI4-Lite registers
// Assumes: external master drives serial clock no faster than core clock / 6
// Notes: data phase option is not offered; output changes on the shift edge
// How it works
// - the master supplies the clock; we shift data on its edges, never make one
// - serial clock is sampled by the core clock; master stays below core clock / 6
// - interrupt fires at frame end (single) or on buffer empty (continuous)
// - overrun is the only error: new frame starts with nothing loaded
// - clock phase bit 0 selects forward phase, 1 selects reverse phase
`timescale 1ns/1ps
`default_nettype none
module cst_slave_tx
    import cst_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial link
    input wire logic i_serial_clock_pin_ch2,
    output logic o_serial_out_pin_ch2,
    // event
    output logic o_serial_transfer_irq_ch2
);
    // registers
    logic [4:0] ctrl_reg;
    logic [7:0] buf_reg;
    logic buf_full_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic busy_reg;
    logic overrun_error_flag_reg;
    logic irq_reg;
    logic peripheral_power_enable_reg;
    logic [3:0] unit_prescaler_select_reg;
    logic sck_prev_reg;
    logic [7:0] aw_addr_reg;
    logic aw_have_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_have_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic rvalid_reg;
    logic [1:0] bresp_reg;
    logic bvalid_reg;
    logic so_reg;

    // named fields of control
    wire enable = ctrl_reg[CST_CTRL_EN];
    wire clock_phase_select = ctrl_reg[CST_CTRL_PHASE];
    wire lsb_first = ctrl_reg[CST_CTRL_LSB];
    wire len7 = ctrl_reg[CST_CTRL_LEN7];
    wire cont_mode = ctrl_reg[CST_CTRL_CONT];
    wire [3:0] frame_len = len7 ? CST_LEN_7 : CST_LEN_8;

    // serial clock crosses into the core domain through two flops
    logic sck_sync;
    cst_sync u_sck_sync (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_async(i_serial_clock_pin_ch2),
        .o_sync(sck_sync)
    );

    // edge finding on the sampled clock; idle level is high in forward phase
    wire sck_fall = sck_prev_reg & ~sck_sync;
    wire sck_rise = ~sck_prev_reg & sck_sync;
    wire shift_edge = enable & (clock_phase_select ? sck_rise : sck_fall);
    wire last_bit = busy_reg & (bit_cnt_reg == frame_len - 4'h1);

    // bit picked from a byte in the selected order
    function automatic logic pick_bit(input logic [7:0] d, input logic lsb, input logic l7);
        pick_bit = lsb ? d[0] : (l7 ? d[6] : d[7]);
    endfunction

    // next shift contents after one bit goes out
    function automatic logic [7:0] advance(input logic [7:0] d, input logic lsb);
        advance = lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
    endfunction

    // frame start: load buffer, or flag overrun when empty
    wire start_frame = shift_edge & ~busy_reg;
    wire next_frame = shift_edge & last_bit;
    wire want_data = start_frame | next_frame;
    wire take_buf = want_data & buf_full_reg & ~(next_frame & ~cont_mode);
    wire overrun_event = start_frame & ~buf_full_reg;
    wire frame_done = next_frame; // frame end
    wire buf_empty_event = take_buf & cont_mode;
    wire irq_event = cont_mode ? buf_empty_event : frame_done;

    // axi decode
    wire wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
    wire rd_fire = s_axi_arvalid & ~rvalid_reg;
    wire wr_ctrl = wr_fire & (aw_addr_reg == CST_OFF_CTRL) & w_strb_reg[0];
    wire wr_data = wr_fire & (aw_addr_reg == CST_OFF_DATA) & w_strb_reg[0];
    wire wr_stat = wr_fire & (aw_addr_reg == CST_OFF_STAT) & w_strb_reg[0];
    wire wr_pwr = wr_fire & (aw_addr_reg == CST_OFF_PWR) & w_strb_reg[0];
    wire wr_pres = wr_fire & (aw_addr_reg == CST_OFF_PRES) & w_strb_reg[0];
    wire wr_hit = (aw_addr_reg == CST_OFF_CTRL) | (aw_addr_reg == CST_OFF_DATA) |
        (aw_addr_reg == CST_OFF_STAT) | (aw_addr_reg == CST_OFF_PWR) | (aw_addr_reg == CST_OFF_PRES);
    wire [31:0] stat_word = {28'h0000000, buf_full_reg, busy_reg, irq_reg, overrun_error_flag_reg};
    wire rd_hit = (s_axi_araddr == CST_OFF_CTRL) | (s_axi_araddr == CST_OFF_DATA) |
        (s_axi_araddr == CST_OFF_STAT) | (s_axi_araddr == CST_OFF_PWR) | (s_axi_araddr == CST_OFF_PRES);
    wire [31:0] rd_word = (s_axi_araddr == CST_OFF_CTRL) ? {27'h0000000, ctrl_reg} :
        (s_axi_araddr == CST_OFF_DATA) ? {24'h000000, buf_reg} :
        (s_axi_araddr == CST_OFF_STAT) ? stat_word :
        (s_axi_araddr == CST_OFF_PWR) ? {31'h00000000, peripheral_power_enable_reg} :
        (s_axi_araddr == CST_OFF_PRES) ? {28'h0000000, unit_prescaler_select_reg} : 32'h00000000;

    // handshake outputs
    assign s_axi_awready = ~aw_have_reg;
    assign s_axi_wready = ~w_have_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign o_serial_out_pin_ch2 = so_reg;
    assign o_serial_transfer_irq_ch2 = irq_reg;

    // write channel capture; each channel is held until both are in
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= CST_RESP_OK;
        end else begin
            if (s_axi_awvalid & ~aw_have_reg) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid & ~w_have_reg) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_hit ? CST_RESP_OK : CST_RESP_SLVERR;
            end else if (bvalid_reg & s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // read channel; unmapped addresses answer slverr with zero data
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= CST_RESP_OK;
        end else if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_hit ? CST_RESP_OK : CST_RESP_SLVERR;
        end else if (rvalid_reg & s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // configuration registers; prescaler write is not policed, software waits
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_reg <= 5'h00;
            peripheral_power_enable_reg <= 1'b0;
            unit_prescaler_select_reg <= 4'h0;
        end else begin
            if (wr_ctrl) ctrl_reg <= w_data_reg[4:0];
            if (wr_pwr) peripheral_power_enable_reg <= w_data_reg[0];
            if (wr_pres) unit_prescaler_select_reg <= w_data_reg[3:0];
        end
    end

    // transmit buffer; a load by the shifter wins over a software write
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            buf_reg <= 8'h00;
            buf_full_reg <= 1'b0;
        end else if (take_buf) begin
            buf_full_reg <= 1'b0;
        end else if (wr_data) begin
            buf_reg <= w_data_reg[7:0];
            buf_full_reg <= 1'b1;
        end
    end

    // shifter driven only by edges of the master's clock
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
            so_reg <= 1'b1;
            sck_prev_reg <= 1'b1;
        end else begin
            sck_prev_reg <= sck_sync;
            if (take_buf) begin
                shift_reg <= advance(buf_reg, lsb_first);
                so_reg <= pick_bit(buf_reg, lsb_first, len7);
                bit_cnt_reg <= 4'h0;
                busy_reg <= 1'b1;
            end else if (next_frame) begin
                busy_reg <= 1'b0;
                bit_cnt_reg <= 4'h0;
            end else if (shift_edge & busy_reg) begin
                so_reg <= pick_bit(shift_reg, lsb_first, len7);
                shift_reg <= advance(shift_reg, lsb_first);
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // sticky flags; hardware set wins over software clear (write 1 to clear)
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            overrun_error_flag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            if (overrun_event) overrun_error_flag_reg <= 1'b1;
            else if (wr_stat & w_data_reg[CST_STAT_OVR]) overrun_error_flag_reg <= 1'b0;
            if (irq_event) irq_reg <= 1'b1;
            else if (wr_stat & w_data_reg[CST_STAT_IRQ]) irq_reg <= 1'b0;
        end
    end
endmodule // cst_slave_tx
`default_nettype wire

// [core/cst_sync.sv]
// Purpose: two-flop synchroniser for one level from outside the clock domain
// Assumes: single core clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module cst_sync (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // level
    input wire logic i_async,
    output logic o_sync
);
    logic meta_reg;

    // two stages against metastability
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule // cst_sync
`default_nettype wire

// [inc/cst_pkg.sv]
// Purpose: constants for the three-wire slave transmit channel
// Assumes: 100 MHz core clock, AXI4-Lite register access
// Notes: offsets are byte addresses of aligned 32-bit words
package cst_pkg;
    // register byte offsets
    localparam logic [7:0] CST_OFF_CTRL = 8'h00;
    localparam logic [7:0] CST_OFF_DATA = 8'h04;
    localparam logic [7:0] CST_OFF_STAT = 8'h08;
    localparam logic [7:0] CST_OFF_PWR = 8'h0C;
    localparam logic [7:0] CST_OFF_PRES = 8'h10;
    // control field positions
    localparam int CST_CTRL_EN = 0;
    localparam int CST_CTRL_PHASE = 1;
    localparam int CST_CTRL_LSB = 2;
    localparam int CST_CTRL_LEN7 = 3;
    localparam int CST_CTRL_CONT = 4;
    // status field positions
    localparam int CST_STAT_OVR = 0;
    localparam int CST_STAT_IRQ = 1;
    localparam int CST_STAT_BUSY = 2;
    localparam int CST_STAT_FULL = 3;
    // frame lengths in bits
    localparam logic [3:0] CST_LEN_8 = 4'h8;
    localparam logic [3:0] CST_LEN_7 = 4'h7;
    // clocks software must wait after power enable before prescaler write
    localparam logic [2:0] CST_PWR_WAIT = 3'h4;
    localparam logic [1:0] CST_RESP_OK = 2'h0;
    localparam logic [1:0] CST_RESP_SLVERR = 2'h2;
endpackage

// [testbench/cst_master_model.sv]
// Purpose: external master that clocks the channel and collects its bits
// Assumes: link clock period of 125 ns, under core clock / 6
// Notes: clock rests at its idle level between frames
`timescale 1ns/1ps
`default_nettype none
module cst_master_model (
    // link clock to the channel
    output logic o_sclk,
    // data from the channel
    input wire logic i_sdo
);
    localparam realtime half_ns = 62.5;
    initial o_sclk = 1'b1;
    // nb bits, then one closing shift edge; sampling on the opposite edge
    task automatic run(input logic ph, input int nb, output logic [15:0] got);
        got = 16'h0000;
        o_sclk = ph ? 1'b0 : 1'b1;
        #half_ns;
        for (int i = 0; i <= nb; i++) begin
            o_sclk = ~o_sclk;
            #half_ns;
            if (i < nb) got = {got[14:0], i_sdo};
            o_sclk = ~o_sclk;
            #half_ns;
        end
    endtask
endmodule // cst_master_model
`default_nettype wire

// [testbench/cst_slave_tx_assertions.sv]
// Purpose: port checks for the slave transmit channel
// Assumes: one core clock domain, async active-low reset
// Notes: serial pin timing is judged in core cycles since a link clock move
`timescale 1ns/1ps
`default_nettype none
module cst_slave_tx_assertions (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // bus handshakes
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // serial link and event
    input wire logic i_serial_clock_pin_ch2,
    input wire logic o_serial_out_pin_ch2,
    input wire logic o_serial_transfer_irq_ch2
);
    logic sclk_q;
    logic [3:0] since;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    // cycles since the link clock moved; saturates so idle gaps never wrap
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sclk_q <= 1'b1;
            since <= 4'hF;
        end else begin
            sclk_q <= i_serial_clock_pin_ch2;
            since <= (sclk_q != i_serial_clock_pin_ch2) ? 4'h0 : ((since == 4'hF) ? since : since + 4'h1);
        end
    end
    sequence s_after_link; since inside {[4'h1:4'h8]}; endsequence
    sequence s_ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    property p_out_follows; $changed(o_serial_out_pin_ch2) |-> s_after_link; endproperty
    a_out_follows: assert property (p_out_follows) else $error("serial out moved off a link edge");
    property p_irq_rise; $rose(o_serial_transfer_irq_ch2) |-> s_after_link; endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose off a link edge");
    property p_irq_hold; $fell(o_serial_transfer_irq_ch2) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without a write");
    property p_r_answer; s_ar_taken |=> s_axi_rvalid; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_r_stand; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_r_stand: assert property (p_r_stand) else $error("read answer withdrawn");
    property p_b_stand; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_stand: assert property (p_b_stand) else $error("write answer withdrawn");
endmodule // cst_slave_tx_assertions
`default_nettype wire

// [testbench/test_csi_slave_transmit_channel.sv]
// Purpose: self-checking bench for the slave transmit channel
// Assumes: register map and serial timing as handed over
// Notes: frame data comes from an lfsr with a fixed start
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("Error at %0t: got %h want %h", $time, a, b); end end
module test_csi_slave_transmit_channel;
    import cst_pkg::*;
    logic i_core_clk = 1'b0, i_rstn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lfsr = 32'hA53771C9;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic i_serial_clock_pin_ch2, o_serial_out_pin_ch2, o_serial_transfer_irq_ch2;
    int n_fail = 0, tests_run = 0;
    cst_slave_tx dut (.i_core_clk, .i_rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_serial_clock_pin_ch2,
        .o_serial_out_pin_ch2, .o_serial_transfer_irq_ch2);
    cst_master_model u_mst (.o_sclk(i_serial_clock_pin_ch2), .i_sdo(o_serial_out_pin_ch2));
    // core clock and a watchdog well past the expected run length
    always #5 i_core_clk = ~i_core_clk;
    initial begin #200000; n_fail++; report_and_stop(); end
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
        return lfsr;
    endfunction
    // bit order on the wire: first bit lands highest in the collected word
    function automatic logic [7:0] order(input logic [7:0] d, input logic lsb, input int n);
        order = 8'h00;
        for (int i = 0; i < n; i++) order[n-1-i] = lsb ? d[i] : d[n-1-i];
    endfunction
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge i_core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        while (s_axi_bvalid !== 1'b1) @(posedge i_core_clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] w, input logic [1:0] rs);
        @(posedge i_core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge i_core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge i_core_clk); while (s_axi_rvalid !== 1'b1);
        `CHK(s_axi_rdata & m, w)
        `CHK(s_axi_rresp, rs)
        s_axi_rready <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("Checks run %0d, failed %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // every phase, order and length in single mode, then continuous, overrun, bad address
    initial begin
        logic [31:0] d, d2;
        logic [15:0] got;
        repeat (3) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        wr(CST_OFF_PWR, 32'h1);
        repeat (4) @(posedge i_core_clk);
        wr(CST_OFF_PRES, 32'h3);
        for (int k = 0; k < 8; k++) begin
            d = rnd();
            wr(CST_OFF_CTRL, {27'h0, 1'b0, k[2:0], 1'b1});
            wr(CST_OFF_DATA, d);
            fork
                u_mst.run(k[0], k[2] ? 7 : 8, got);
                #303 `CHK(o_serial_transfer_irq_ch2, 1'b0)
            join
            `CHK(got[7:0], order(d[7:0], k[1], k[2] ? 7 : 8))
            `CHK(o_serial_transfer_irq_ch2, 1'b1)
            rdchk(CST_OFF_STAT, 32'h3, 32'h2, CST_RESP_OK);
            wr(CST_OFF_STAT, 32'h2);
        end
        wr(CST_OFF_CTRL, 32'h11);
        d = rnd();
        d2 = rnd();
        wr(CST_OFF_DATA, d);
        fork
            u_mst.run(1'b0, 16, got);
            #303 begin
                `CHK(o_serial_transfer_irq_ch2, 1'b1)
                wr(CST_OFF_STAT, 32'h2);
                wr(CST_OFF_DATA, d2);
            end
        join
        `CHK(got, {order(d[7:0], 1'b0, 8), order(d2[7:0], 1'b0, 8)})
        wr(CST_OFF_CTRL, 32'h1);
        wr(CST_OFF_STAT, 32'h3);
        rdchk(CST_OFF_STAT, 32'h3, 32'h0, CST_RESP_OK);
        u_mst.run(1'b0, 8, got);
        rdchk(CST_OFF_STAT, 32'h1, 32'h1, CST_RESP_OK);
        wr(CST_OFF_STAT, 32'h1);
        rdchk(CST_OFF_STAT, 32'h1, 32'h0, CST_RESP_OK);
        rdchk(8'h40, 32'hFFFFFFFF, 32'h0, CST_RESP_SLVERR);
        report_and_stop();
    end
endmodule // test_csi_slave_transmit_channel
bind cst_slave_tx cst_slave_tx_assertions u_chk (.i_core_clk, .i_rstn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_bvalid, .s_axi_bready, .i_serial_clock_pin_ch2, .o_serial_out_pin_ch2, .o_serial_transfer_irq_ch2);
`default_nettype wire
